// file: rtl/timer_zero_defines.svh
`ifndef TIMER_ZERO_DEFINES_SVH
`define TIMER_ZERO_DEFINES_SVH

// ****************************************************************
// Register addresses.
// ****************************************************************
`define TZ_ADDR_W 12
`define TZ_ADDR_COUNT_LOW 12'h19C
`define TZ_ADDR_COUNT_HIGH 12'h19D
`define TZ_ADDR_CONTROL_ZERO 12'h19E
`define TZ_ADDR_CONTROL_ONE 12'h19F
`define TZ_ADDR_IRQ_STATUS 12'h1A0
`define TZ_ADDR_IRQ_MASK 12'h1A1

// ****************************************************************
// Field positions.
// ****************************************************************
`define TZ_C0_ENABLE 7
`define TZ_C0_OUT 5
`define TZ_C0_WIDE 4
`define TZ_C0_OUTDIV_MSB 3
`define TZ_C0_OUTDIV_LSB 0
`define TZ_C1_SRC_MSB 7
`define TZ_C1_SRC_LSB 5
`define TZ_C1_UNSYNC 4
`define TZ_C1_INDIV_MSB 3
`define TZ_C1_INDIV_LSB 0
`define TZ_IRQ_TIMER 0

// ****************************************************************
// Reset values and constants.
// ****************************************************************
`define TZ_RST_BYTE 8'h00
`define TZ_RST_HIGH 8'hFF
`define TZ_RST_NIBBLE 4'h0
`define TZ_ONE_NIBBLE 4'h1
`define TZ_RST_SRC 3'h0
`define TZ_ONE_BYTE 8'h01
`define TZ_ALL_ONES_WORD 16'hFFFF
`define TZ_ONE_WORD 16'h0001
`define TZ_INSTR_LAST 2'h3
`define TZ_INSTR_ONE 2'h1
`define TZ_INSTR_RST 2'h0

`endif

// file: rtl/timer_zero_pkg.sv
package timer_zero_pkg;

	// ****************************************************************
	// Clock source selection codes.
	// ****************************************************************
	typedef enum logic [2:0] {
		SRC_PIN = 3'h0,
		SRC_PIN_INV = 3'h1,
		SRC_INSTR = 3'h2,
		SRC_HIGH_OSC = 3'h3,
		SRC_LOW_OSC = 3'h4,
		SRC_MID_OSC = 3'h5,
		SRC_SECONDARY = 3'h6,
		SRC_LOGIC_CELL = 3'h7
	} clk_src_e;

endpackage : timer_zero_pkg

// file: rtl/timer_zero_control.sv
`include "timer_zero_defines.svh"

// Overview of operation
// - Synchronised mode stops counting during Sleep.
// - Unsynchronised mode counts in Sleep, wakes.
// - Enable bit runs timer; resets to zero.
// - Read-only bit mirrors timer output level.
// - Width bit selects 16-bit or 8-bit.
// - Output divider divides events by value+1.
// - Source field selects one of eight clocks.
// - Unsync bit bypasses instruction clock synchronisation.
// - Input divider divides by two to value.
// - 8-bit mode: high register is period.
// - 16-bit mode: high and low form counter.
// - Reset: high all ones, others zero.
// - Match clears low, reloads period buffer.
// - Output toggles per postscaled event, sets flag.
// - Low or control writes clear both scalers.
// - 16-bit low read latches, write transfers high.
module timer_zero_control #(
	parameter int PRE_W = 15
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [`TZ_ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_sleep,
	input wire logic i_input_pin,
	input wire logic i_high_internal_oscillator,
	input wire logic i_low_internal_oscillator,
	input wire logic i_mid_internal_oscillator,
	input wire logic i_secondary_oscillator,
	input wire logic i_logic_cell_one_output,
	output logic o_timer_toggle_output,
	output logic o_irq,
	output logic o_wake
);

	// ****************************************************************
	// Elaboration check.
	// ****************************************************************
	if (PRE_W != 15) begin : g_bad_pre_w
		$error("Prescaler width must be 15.");
	end

	// ****************************************************************
	// Registers and internal state.
	// ****************************************************************
	logic enable_reg;
	logic wide_mode_select_reg;
	logic [3:0] output_divider_reg;
	timer_zero_pkg::clk_src_e clk_src_reg;
	logic unsync_input_reg;
	logic [3:0] input_divider_reg;
	logic [7:0] count_low_reg;
	logic [7:0] count_high_period_reg;
	logic [7:0] count_high_byte_reg;
	logic [7:0] period_buf_reg;
	logic [3:0] post_cnt_reg;
	logic [PRE_W-1:0] pre_cnt_reg;
	logic src_prev_reg;
	logic presc_prev_reg;
	logic sync1_reg;
	logic sync2_reg;
	logic sync3_reg;
	logic pending_reg;
	logic [1:0] instr_div_reg;
	logic timer_irq_flag_reg;
	logic timer_irq_enable_reg;

	logic wr_low;
	logic wr_high;
	logic wr_c0;
	logic wr_c1;
	logic rd_low;
	logic clr_scalers;
	logic instr_en;
	logic src_level;
	logic presc_level;
	logic tick;
	logic period_match;
	logic rollover;
	logic count_event;
	logic post_done;
	logic [15:0] wide_next;

	assign wr_low = i_wr && (i_addr == `TZ_ADDR_COUNT_LOW);
	assign wr_high = i_wr && (i_addr == `TZ_ADDR_COUNT_HIGH);
	assign wr_c0 = i_wr && (i_addr == `TZ_ADDR_CONTROL_ZERO);
	assign wr_c1 = i_wr && (i_addr == `TZ_ADDR_CONTROL_ONE);
	assign rd_low = i_rd && (i_addr == `TZ_ADDR_COUNT_LOW);
	assign clr_scalers = wr_low || wr_c0 || wr_c1;

	// ****************************************************************
	// Control registers.
	// ****************************************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			enable_reg <= 1'b0;
			wide_mode_select_reg <= 1'b0;
			output_divider_reg <= `TZ_RST_NIBBLE;
		end else if (wr_c0) begin
			enable_reg <= i_wdata[`TZ_C0_ENABLE];
			wide_mode_select_reg <= i_wdata[`TZ_C0_WIDE];
			output_divider_reg <= i_wdata[`TZ_C0_OUTDIV_MSB:`TZ_C0_OUTDIV_LSB];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clk_src_reg <= timer_zero_pkg::SRC_PIN;
			unsync_input_reg <= 1'b0;
			input_divider_reg <= `TZ_RST_NIBBLE;
		end else if (wr_c1) begin
			clk_src_reg <= timer_zero_pkg::clk_src_e'(i_wdata[`TZ_C1_SRC_MSB:`TZ_C1_SRC_LSB]);
			unsync_input_reg <= i_wdata[`TZ_C1_UNSYNC];
			input_divider_reg <= i_wdata[`TZ_C1_INDIV_MSB:`TZ_C1_INDIV_LSB];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			timer_irq_enable_reg <= 1'b0;
		end else if (i_wr && (i_addr == `TZ_ADDR_IRQ_MASK)) begin
			timer_irq_enable_reg <= i_wdata[`TZ_IRQ_TIMER];
		end
	end

	// ****************************************************************
	// Instruction clock divider.
	// ****************************************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			instr_div_reg <= `TZ_INSTR_RST;
		end else begin
			instr_div_reg <= instr_div_reg + `TZ_INSTR_ONE;
		end
	end

	assign instr_en = (instr_div_reg == `TZ_INSTR_LAST) && !i_sleep;

	// ****************************************************************
	// Clock source selection.
	// ****************************************************************
	always_comb begin
		case (clk_src_reg)
			timer_zero_pkg::SRC_PIN: begin
				src_level = i_input_pin;
			end
			timer_zero_pkg::SRC_PIN_INV: begin
				src_level = !i_input_pin;
			end
			timer_zero_pkg::SRC_INSTR: begin
				src_level = instr_div_reg[1] && !i_sleep;
			end
			timer_zero_pkg::SRC_HIGH_OSC: begin
				src_level = i_high_internal_oscillator;
			end
			timer_zero_pkg::SRC_LOW_OSC: begin
				src_level = i_low_internal_oscillator;
			end
			timer_zero_pkg::SRC_MID_OSC: begin
				src_level = i_mid_internal_oscillator;
			end
			timer_zero_pkg::SRC_SECONDARY: begin
				src_level = i_secondary_oscillator;
			end
			default: begin
				src_level = i_logic_cell_one_output;
			end
		endcase
	end

	// ****************************************************************
	// Input prescaler.
	// ****************************************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			src_prev_reg <= 1'b0;
			pre_cnt_reg <= '0;
		end else begin
			src_prev_reg <= src_level;
			if (clr_scalers || !enable_reg) begin
				pre_cnt_reg <= '0;
			end else if (src_level && !src_prev_reg) begin
				pre_cnt_reg <= pre_cnt_reg + PRE_W'(1);
			end
		end
	end

	always_comb begin
		if (input_divider_reg == `TZ_RST_NIBBLE) begin
			presc_level = src_level;
		end else begin
			presc_level = pre_cnt_reg[input_divider_reg - `TZ_ONE_NIBBLE];
		end
	end

	// ****************************************************************
	// Synchroniser and count tick.
	// ****************************************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
			presc_prev_reg <= 1'b0;
		end else begin
			sync1_reg <= presc_level;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			presc_prev_reg <= presc_level;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pending_reg <= 1'b0;
		end else if (clr_scalers) begin
			pending_reg <= 1'b0;
		end else if (sync2_reg && !sync3_reg) begin
			pending_reg <= 1'b1;
		end else if (instr_en) begin
			pending_reg <= 1'b0;
		end
	end

	always_comb begin
		if (!enable_reg) begin
			tick = 1'b0;
		end else if (unsync_input_reg) begin
			tick = presc_level && !presc_prev_reg;
		end else begin
			tick = pending_reg && instr_en;
		end
	end

	// ****************************************************************
	// Counter.
	// ****************************************************************
	assign wide_next = {count_high_byte_reg, count_low_reg} + `TZ_ONE_WORD;
	assign period_match = !wide_mode_select_reg && (count_low_reg == period_buf_reg);
	assign rollover = wide_mode_select_reg && ({count_high_byte_reg, count_low_reg} == `TZ_ALL_ONES_WORD);
	assign count_event = tick && (period_match || rollover);

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_low_reg <= `TZ_RST_BYTE;
			count_high_byte_reg <= `TZ_RST_BYTE;
			period_buf_reg <= `TZ_RST_HIGH;
		end else if (wr_low) begin
			count_low_reg <= i_wdata;
			if (wide_mode_select_reg) begin
				count_high_byte_reg <= count_high_period_reg;
			end
		end else if (tick) begin
			if (wide_mode_select_reg) begin
				count_low_reg <= wide_next[7:0];
				count_high_byte_reg <= wide_next[15:8];
			end else if (period_match) begin
				count_low_reg <= `TZ_RST_BYTE;
				period_buf_reg <= count_high_period_reg;
			end else begin
				count_low_reg <= count_low_reg + `TZ_ONE_BYTE;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_high_period_reg <= `TZ_RST_HIGH;
		end else if (wr_high) begin
			count_high_period_reg <= i_wdata;
		end else if (rd_low && wide_mode_select_reg) begin
			count_high_period_reg <= count_high_byte_reg;
		end
	end

	// ****************************************************************
	// Postscaler, output and interrupt.
	// ****************************************************************
	assign post_done = count_event && (post_cnt_reg == output_divider_reg);

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			post_cnt_reg <= `TZ_RST_NIBBLE;
		end else if (clr_scalers) begin
			post_cnt_reg <= `TZ_RST_NIBBLE;
		end else if (post_done) begin
			post_cnt_reg <= `TZ_RST_NIBBLE;
		end else if (count_event) begin
			post_cnt_reg <= post_cnt_reg + `TZ_ONE_NIBBLE;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_timer_toggle_output <= 1'b0;
		end else if (post_done) begin
			o_timer_toggle_output <= !o_timer_toggle_output;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			timer_irq_flag_reg <= 1'b0;
		end else if (post_done) begin
			timer_irq_flag_reg <= 1'b1;
		end else if (i_wr && (i_addr == `TZ_ADDR_IRQ_STATUS) && i_wdata[`TZ_IRQ_TIMER]) begin
			timer_irq_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
			o_wake <= 1'b0;
		end else begin
			o_irq <= timer_irq_flag_reg && timer_irq_enable_reg;
			o_wake <= i_sleep && timer_irq_flag_reg && timer_irq_enable_reg;
		end
	end

	// ****************************************************************
	// Read data.
	// ****************************************************************
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= `TZ_RST_BYTE;
		end else if (i_rd) begin
			case (i_addr)
				`TZ_ADDR_COUNT_LOW: begin
					o_rdata <= count_low_reg;
				end
				`TZ_ADDR_COUNT_HIGH: begin
					o_rdata <= count_high_period_reg;
				end
				`TZ_ADDR_CONTROL_ZERO: begin
					o_rdata <= {enable_reg, 1'b0, o_timer_toggle_output, wide_mode_select_reg,
						output_divider_reg};
				end
				`TZ_ADDR_CONTROL_ONE: begin
					o_rdata <= {clk_src_reg, unsync_input_reg, input_divider_reg};
				end
				`TZ_ADDR_IRQ_STATUS: begin
					o_rdata <= {7'h00, timer_irq_flag_reg};
				end
				`TZ_ADDR_IRQ_MASK: begin
					o_rdata <= {7'h00, timer_irq_enable_reg};
				end
				default: begin
					o_rdata <= `TZ_RST_BYTE;
				end
			endcase
		end else begin
			o_rdata <= `TZ_RST_BYTE;
		end
	end

endmodule : timer_zero_control

// file: verif/timer_zero_control_asserts.sv
`include "timer_zero_defines.svh"
module timer_zero_control_asserts (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [`TZ_ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_sleep,
	input wire logic o_timer_toggle_output,
	input wire logic o_irq,
	input wire logic o_wake
);
	timeunit 1ns;
	timeprecision 1ns;
	logic en_reg;
	logic unsync_reg;
	logic mask_reg;
	// ****
	// Shadow copies of the controls that the checks depend on.
	// ****
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			en_reg <= 1'h0;
			unsync_reg <= 1'h0;
			mask_reg <= 1'h0;
		end else if (i_wr) begin
			if (i_addr == `TZ_ADDR_CONTROL_ZERO) en_reg <= i_wdata[7];
			if (i_addr == `TZ_ADDR_CONTROL_ONE) unsync_reg <= i_wdata[4];
			if (i_addr == `TZ_ADDR_IRQ_MASK) mask_reg <= i_wdata[0];
		end
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_rd_c0;
		i_rd && i_addr == `TZ_ADDR_CONTROL_ZERO;
	endsequence
	sequence s_off;
		!en_reg [*2];
	endsequence
	sequence s_sleep_sync;
		(i_sleep && !unsync_reg) [*3];
	endsequence
	property p_enable_bit;
		s_rd_c0 |=> o_rdata[7] == $past(en_reg);
	endproperty
	property p_out_bit;
		s_rd_c0 |=> o_rdata[5] == $past(o_timer_toggle_output);
	endproperty
	property p_off_hold;
		s_off |=> $stable(o_timer_toggle_output);
	endproperty
	property p_sleep_hold;
		s_sleep_sync |=> $stable(o_timer_toggle_output);
	endproperty
	property p_wake_sleep;
		o_wake |-> $past(i_sleep) && o_irq;
	endproperty
	property p_irq_mask;
		$rose(o_irq) |-> $past(mask_reg);
	endproperty
	property p_toggle_irq;
		$changed(o_timer_toggle_output) && mask_reg |-> ##[1:2] o_irq;
	endproperty
	property p_irq_off;
		!mask_reg [*2] |-> !o_irq;
	endproperty
	a_enable_bit: assert property (p_enable_bit) else $error("enable bit read back wrong");
	a_out_bit: assert property (p_out_bit) else $error("output bit read back wrong");
	a_off_hold: assert property (p_off_hold) else $error("output moved while disabled");
	a_sleep_hold: assert property (p_sleep_hold) else $error("sync timer ran in sleep");
	a_wake_sleep: assert property (p_wake_sleep) else $error("wake outside sleep");
	a_irq_mask: assert property (p_irq_mask) else $error("irq rose while masked");
	a_toggle_irq: assert property (p_toggle_irq) else $error("toggle gave no irq");
	a_irq_off: assert property (p_irq_off) else $error("irq high while masked");
endmodule : timer_zero_control_asserts

// file: verif/timer_zero_control_tb.sv
`include "timer_zero_defines.svh"
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin n_mismatch++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module timer_zero_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [2:0] src; logic un; logic [3:0] ind; logic wide; logic [3:0] od; logic [7:0] per;
		logic [15:0] start; int n;} row_s;
	row_s rows [8] = '{'{3'h0, 1'h1, 4'h0, 1'h1, 4'h0, 8'h00, 16'hFFFE, 5},
		'{3'h1, 1'h1, 4'h0, 1'h0, 4'h0, 8'h03, 16'h00FD, 10}, '{3'h2, 1'h0, 4'h0, 1'h1, 4'h0, 8'h00, 16'h0000, 20},
		'{3'h3, 1'h0, 4'h1, 1'h0, 4'h1, 8'h01, 16'h0000, 12}, '{3'h4, 1'h1, 4'h2, 1'h0, 4'h2, 8'h02, 16'h0000, 16},
		'{3'h5, 1'h0, 4'h0, 1'h0, 4'h0, 8'h00, 16'h0000, 6}, '{3'h6, 1'h1, 4'h3, 1'h0, 4'h0, 8'h05, 16'h0000, 20},
		'{3'h7, 1'h0, 4'h0, 1'h1, 4'h3, 8'h00, 16'hFFFC, 8}};
	logic i_ref_clk = 1'h0, i_rst_n = 1'h0, i_wr = 1'h0, i_rd = 1'h0, i_sleep = 1'h0;
	logic pulse = 1'h0, decoy = 1'h0, tog = 1'h0, tog_prev = 1'h0;
	logic [11:0] i_addr = 12'h000;
	logic [7:0] i_wdata = 8'h00, o_rdata, d, m_buf = 8'hFF;
	logic [2:0] sel = 3'h0;
	logic [15:0] m_cnt;
	logic o_timer_toggle_output, o_irq, o_wake;
	int n_mismatch = 0, compares = 0, n_tog = 0, cyc = 0, m_ev, t;
	row_s r;
	timer_zero_control timer_zero_control_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep),
		.i_input_pin(sel == 3'h0 ? pulse : (sel == 3'h1 ? ~pulse : decoy)),
		.i_high_internal_oscillator(sel == 3'h3 ? pulse : decoy), .i_low_internal_oscillator(sel == 3'h4 ? pulse : decoy),
		.i_mid_internal_oscillator(sel == 3'h5 ? pulse : decoy), .i_secondary_oscillator(sel == 3'h6 ? pulse : decoy),
		.i_logic_cell_one_output(sel == 3'h7 ? pulse : decoy), .o_timer_toggle_output(o_timer_toggle_output),
		.o_irq(o_irq), .o_wake(o_wake));
	always #10 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) begin
		decoy <= ~decoy;
		tog_prev <= o_timer_toggle_output;
		if (o_timer_toggle_output !== tog_prev) n_tog++;
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge i_ref_clk);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_ref_clk);
		i_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge i_ref_clk);
		i_rd <= 1'h1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'h0;
		#1 d = o_rdata;
	endtask : rd
	task automatic pulses(input int n);
		repeat (n) begin
			pulse <= 1'h1;
			repeat (4) @(posedge i_ref_clk);
			pulse <= 1'h0;
			repeat (4) @(posedge i_ref_clk);
		end
		repeat (12) @(posedge i_ref_clk);
	endtask : pulses
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	initial begin
		repeat (4) @(posedge i_ref_clk);
		i_rst_n <= 1'h1;
		wr(`TZ_ADDR_IRQ_MASK, 8'h01);
		foreach (rows[i]) begin
			r = rows[i];
			sel <= r.src;
			wr(`TZ_ADDR_CONTROL_ZERO, {3'h0, r.wide, r.od});
			n_tog = 0;
			wr(`TZ_ADDR_COUNT_HIGH, r.wide ? r.start[15:8] : r.per);
			wr(`TZ_ADDR_COUNT_LOW, r.start[7:0]);
			wr(`TZ_ADDR_CONTROL_ONE, {r.src, r.un, r.ind});
			wr(`TZ_ADDR_CONTROL_ZERO, {3'h4, r.wide, r.od});
			if (r.src == 3'h2) repeat (4 * r.n) @(posedge i_ref_clk);
			else pulses(r.n);
			wr(`TZ_ADDR_CONTROL_ZERO, {3'h0, r.wide, r.od});
			pulses(3);
			m_cnt = r.start;
			m_ev = 0;
			t = r.ind == 0 ? r.n : (r.n + (1 << (r.ind - 1))) >> r.ind;
			if (r.src != 3'h2) for (int k = 0; k < t; k++) begin
				if (r.wide) begin
					m_ev += m_cnt == 16'hFFFF;
					m_cnt++;
				end else if (m_cnt[7:0] == m_buf) begin
					m_cnt = 16'h0000;
					m_buf = r.per;
					m_ev++;
				end else m_cnt++;
			end
			rd(`TZ_ADDR_COUNT_LOW);
			if (r.src == 3'h2) `CHK("count_low_instr", 1'h1, d >= 8'h10 && d <= 8'h17)
			else `CHK("count_low", m_cnt[7:0], d)
			rd(`TZ_ADDR_COUNT_HIGH);
			`CHK("count_high", r.wide ? m_cnt[15:8] : r.per, d)
			`CHK("toggles", m_ev / (r.od + 1), n_tog)
			tog = tog ^ n_tog[0];
			rd(`TZ_ADDR_CONTROL_ZERO);
			`CHK("control_zero", {2'h0, tog, r.wide, r.od}, d)
			`CHK("irq", n_tog != 0, o_irq)
			wr(`TZ_ADDR_IRQ_STATUS, 8'h01);
			repeat (2) @(posedge i_ref_clk);
			`CHK("irq_clear", 1'h0, o_irq)
		end
		sel <= 3'h0;
		i_sleep <= 1'h1;
		wr(`TZ_ADDR_CONTROL_ZERO, 8'h10);
		wr(`TZ_ADDR_COUNT_HIGH, 8'hFF);
		wr(`TZ_ADDR_COUNT_LOW, 8'hFF);
		wr(`TZ_ADDR_CONTROL_ONE, 8'h00);
		wr(`TZ_ADDR_CONTROL_ZERO, 8'h90);
		pulses(4);
		rd(`TZ_ADDR_COUNT_LOW);
		`CHK("sleep_sync", 8'hFF, d)
		wr(`TZ_ADDR_CONTROL_ONE, 8'h10);
		pulses(2);
		rd(`TZ_ADDR_COUNT_LOW);
		`CHK("sleep_unsync", 8'h01, d)
		`CHK("wake", 1'h1, o_wake)
		i_sleep <= 1'h0;
		i_rst_n <= 1'h0;
		@(posedge i_ref_clk);
		i_rst_n <= 1'h1;
		for (int a = 0; a < 7; a++) begin
			rd(12'h19C + a[11:0]);
			`CHK("reset_read", a == 1 ? 8'hFF : 8'h00, d)
		end
		wr(`TZ_ADDR_CONTROL_ZERO, 8'h20);
		rd(`TZ_ADDR_CONTROL_ZERO);
		`CHK("read_only_bit", 8'h00, d)
		wr(`TZ_ADDR_CONTROL_ONE, 8'h12);
		wr(`TZ_ADDR_CONTROL_ZERO, 8'h80);
		pulses(1);
		wr(`TZ_ADDR_COUNT_LOW, 8'hFF);
		pulses(1);
		rd(`TZ_ADDR_COUNT_LOW);
		`CHK("prescaler_clear", 8'hFF, d)
		pulses(2);
		rd(`TZ_ADDR_COUNT_LOW);
		`CHK("period_wrap", 8'h00, d)
		rd(`TZ_ADDR_IRQ_STATUS);
		`CHK("flag_masked", 8'h01, d)
		`CHK("irq_masked", 1'h0, o_irq)
		summarize();
	end
endmodule : timer_zero_control_tb
bind timer_zero_control timer_zero_control_asserts timer_zero_control_asserts_inst (.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_sleep(i_sleep), .o_timer_toggle_output(o_timer_toggle_output), .o_irq(o_irq), .o_wake(o_wake));
